// ---- src/p1fm_pkg.sv ----
// Package with register map, field layout and function codes of the pin-1 function mux.
package p1fm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the register bus.
    localparam logic [7:0] P1FM_CFG_ADDR = 8'h0c;   // Pin configuration register.
    localparam logic [7:0] P1FM_CTRL_ADDR = 8'h10;  // Direct output level register.
    localparam logic [7:0] P1FM_STAT_ADDR = 8'h14;  // Pin status register.

    // Field positions inside the pin configuration register.
    localparam int P1FM_CODE_LSB = 0;   // Function code, bits 4 down to 0.
    localparam int P1FM_CODE_MSB = 4;
    localparam int P1FM_PUP_BIT = 5;    // Pull-up enable bit.
    localparam int P1FM_DRV_LSB = 6;    // Drive strength, bits 7 down to 6.
    localparam int P1FM_DRV_MSB = 7;

    // Field positions inside the own control and status registers.
    localparam int P1FM_DOUT_BIT = 0;   // Software level for the direct output.
    localparam int P1FM_STAT_PIN_BIT = 0;   // Sampled pin level.
    localparam int P1FM_STAT_OE_BIT = 1;    // Pin driven by the block.
    localparam int P1FM_STAT_PUP_BIT = 2;   // Pull-up connected.
    localparam int P1FM_STAT_ANA_BIT = 3;   // Pin handed to analog circuitry.

    // Reset values.
    localparam logic [7:0] P1FM_CFG_RESET = 8'h00;
    localparam logic P1FM_DOUT_RESET = 1'b0;
    localparam logic [31:0] P1FM_RDATA_ZERO = 32'h0000_0000;

    // Function codes of the pin.
    typedef enum logic [4:0] {
        P1FM_F_POR_N = 5'b00000,
        P1FM_F_WAKEUP = 5'b00001,
        P1FM_F_LOWBATT = 5'b00010,
        P1FM_F_DIN = 5'b00011,
        P1FM_F_INT_FALL = 5'b00100,
        P1FM_F_INT_RISE = 5'b00101,
        P1FM_F_INT_CHG = 5'b00110,
        P1FM_F_ADC_IN = 5'b00111,
        P1FM_F_TEST_LO = 5'b01000,
        P1FM_F_DOUT = 5'b01010,
        P1FM_F_TEST_DIG = 5'b01011,
        P1FM_F_TEST_HI = 5'b01101,
        P1FM_F_VREF = 5'b01110,
        P1FM_F_DCLK = 5'b01111,
        P1FM_F_TXDATA = 5'b10000,
        P1FM_F_RETX = 5'b10001,
        P1FM_F_TXSTATE = 5'b10010,
        P1FM_F_TXAFULL = 5'b10011,
        P1FM_F_RXDATA = 5'b10100,
        P1FM_F_RXSTATE = 5'b10101,
        P1FM_F_RXAFULL = 5'b10110,
        P1FM_F_ANT1 = 5'b10111,
        P1FM_F_ANT2 = 5'b11000,
        P1FM_F_PRE_OK = 5'b11001,
        P1FM_F_PRE_BAD = 5'b11010,
        P1FM_F_SYNC = 5'b11011,
        P1FM_F_CCA = 5'b11100,
        P1FM_F_HIGH = 5'b11101
    } p1fm_code_e;

    // Status levels that the radio core offers to the pin.
    typedef struct packed {
        logic por;          // Power-on reset active, high.
        logic wakeup_timer; // Wake-up timer expired.
        logic low_batt;     // Battery below threshold.
        logic tx_state;     // Core in transmit state.
        logic rx_state;     // Core in receive state.
        logic tx_afull;     // Transmit FIFO almost full.
        logic rx_afull;     // Receive FIFO almost full.
        logic rx_data;      // Demodulated receive data.
        logic data_clk;     // Transmit/receive bit clock.
        logic ant1;         // Antenna 1 switch control.
        logic ant2;         // Antenna 2 switch control.
        logic pre_ok;       // Valid preamble detected.
        logic pre_bad;      // Invalid preamble detected.
        logic sync_det;     // Sync word detected.
        logic cca;          // Clear channel assessment result.
    } p1fm_core_s;

    // Inputs that the pin delivers back to the radio core.
    typedef struct packed {
        logic din;          // Direct digital input level.
        logic tx_mod_data;  // Transmit data for direct modulation.
        logic ext_int;      // External interrupt event, one-cycle pulse.
        logic retx_req;     // Retransmission request level.
    } p1fm_to_core_s;

endpackage

// ---- src/p1fm_pin1_mux.sv ----
// Pin-1 function multiplexer with an Avalon-MM register slave.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps

module p1fm_pin1_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire p1fm_pkg::p1fm_core_s core_i,
    output p1fm_pkg::p1fm_to_core_s core_o,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic pin1_pullup_enable_o,
    output logic [1:0] pin1_drive_strength_o,
    output logic analog_en_o
);
    import p1fm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // True for every code that uses the pin as a digital input.
    function automatic logic p1fm_is_din(input logic [4:0] code);
        case (p1fm_code_e'(code))
            P1FM_F_DIN, P1FM_F_INT_FALL, P1FM_F_INT_RISE, P1FM_F_INT_CHG,
            P1FM_F_TXDATA, P1FM_F_RETX: p1fm_is_din = 1'b1;
            default: p1fm_is_din = 1'b0;
        endcase
    endfunction

    // True for the codes that hand the pin to analog circuitry.
    function automatic logic p1fm_is_analog(input logic [4:0] code);
        p1fm_is_analog = (code == P1FM_F_ADC_IN) || (code == P1FM_F_VREF);
    endfunction

    // True for the reserved test codes.
    function automatic logic p1fm_is_test(input logic [4:0] code);
        p1fm_is_test = (code >= P1FM_F_TEST_LO) && (code <= P1FM_F_TEST_HI) &&
                       (code != P1FM_F_DOUT);
    endfunction

    // Returns output enable and level of the pin for a function code.
    function automatic logic [1:0] p1fm_drive(input logic [4:0] code,
                                              input p1fm_core_s c,
                                              input logic dout);
        logic oe;
        logic lvl;
        oe = 1'b1;
        lvl = 1'b0;
        case (p1fm_code_e'(code))
            P1FM_F_POR_N: lvl = ~c.por;
            P1FM_F_WAKEUP: lvl = c.wakeup_timer;
            P1FM_F_LOWBATT: lvl = c.low_batt;
            P1FM_F_DOUT: lvl = dout;
            P1FM_F_DCLK: lvl = c.data_clk;
            P1FM_F_TXSTATE: lvl = c.tx_state;
            P1FM_F_RXSTATE: lvl = c.rx_state;
            P1FM_F_TXAFULL: lvl = c.tx_afull;
            P1FM_F_RXAFULL: lvl = c.rx_afull;
            P1FM_F_RXDATA: lvl = c.rx_data;
            P1FM_F_ANT1: lvl = c.ant1;
            P1FM_F_ANT2: lvl = c.ant2;
            P1FM_F_PRE_OK: lvl = c.pre_ok;
            P1FM_F_PRE_BAD: lvl = c.pre_bad;
            P1FM_F_SYNC: lvl = c.sync_det;
            P1FM_F_CCA: lvl = c.cca;
            P1FM_F_HIGH: lvl = 1'b1;
            default: begin
                // Inputs, analog and test codes release the pin.
                if (p1fm_is_din(code) || p1fm_is_analog(code) || p1fm_is_test(code)) begin
                    oe = 1'b0;
                end else begin
                    lvl = 1'b0;
                end
            end
        endcase
        p1fm_drive = {oe, lvl};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0] cfg_q;          // Pin configuration register.
    logic dout_q;               // Software level of the direct output.
    logic ack_q;                // Answer phase of the bus access.
    logic [31:0] rdata_q;       // Read data register.
    logic pin_o_q;              // Pin level register.
    logic pin_oe_q;             // Pin output enable register.
    logic pup_q;                // Pull-up enable register.
    logic [1:0] drv_q;          // Drive strength register.
    logic ana_q;                // Analog hand-over register.
    logic pin_s_q;              // Sampled pin level, gated by input mode.
    logic pin_prev_q;           // Sampled pin level one cycle earlier.
    p1fm_to_core_s to_core_q;   // Inputs delivered to the core.
    logic [4:0] code;           // Current function code.
    logic bus_wr;               // Write takes effect this edge.
    logic [1:0] drive_nxt;      // Next output enable and level.
    logic pin_d;                // Next gated pin sample.

    // Function code, bus write strobe, next pin drive and gated pin sample.
    assign code = cfg_q[P1FM_CODE_MSB:P1FM_CODE_LSB];
    assign bus_wr = avs_write_i && ack_q;
    assign drive_nxt = p1fm_drive(code, core_i, dout_q);
    // Digital input path is cut unless the code is a digital input.
    assign pin_d = p1fm_is_din(code) ? pin_i : 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave.

    // One wait state: the request is seen, then waitrequest drops for one cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            // Acknowledge lasts one cycle, so every access costs two edges.
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end

    // Read data is built in the cycle the request is seen.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= P1FM_RDATA_ZERO;
        end else if (avs_read_i && !ack_q) begin
            rdata_q <= P1FM_RDATA_ZERO;
            case (avs_address_i)
                P1FM_CFG_ADDR: rdata_q[7:0] <= cfg_q;
                P1FM_CTRL_ADDR: rdata_q[P1FM_DOUT_BIT] <= dout_q;
                P1FM_STAT_ADDR: begin
                    rdata_q[P1FM_STAT_PIN_BIT] <= pin_s_q;
                    rdata_q[P1FM_STAT_OE_BIT] <= pin_oe_q;
                    rdata_q[P1FM_STAT_PUP_BIT] <= pup_q;
                    rdata_q[P1FM_STAT_ANA_BIT] <= ana_q;
                end
                default: rdata_q <= P1FM_RDATA_ZERO;  // Unmapped reads zero.
            endcase
        end
    end

    // Configuration register write, low byte lane only.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= P1FM_CFG_RESET;
        end else if (bus_wr && avs_byteenable_i[0] && avs_address_i == P1FM_CFG_ADDR) begin
            cfg_q <= avs_writedata_i[7:0];
        end
    end

    // Direct output level register.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_q <= P1FM_DOUT_RESET;
        end else if (bus_wr && avs_byteenable_i[0] && avs_address_i == P1FM_CTRL_ADDR) begin
            dout_q <= avs_writedata_i[P1FM_DOUT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin side.

    // Output enable and level follow the function code.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_o_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_oe_q <= drive_nxt[1];
            pin_o_q <= drive_nxt[0];
        end
    end

    // Pull-up, drive strength and analog hand-over controls.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pup_q <= 1'b0;
            drv_q <= 2'b00;
            ana_q <= 1'b0;
        end else begin
            pup_q <= cfg_q[P1FM_PUP_BIT] && p1fm_is_din(code);
            drv_q <= cfg_q[P1FM_DRV_MSB:P1FM_DRV_LSB];
            ana_q <= p1fm_is_analog(code);
        end
    end

    // Pin sampling, current and previous level.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_s_q <= pin_d;
            pin_prev_q <= pin_s_q;
        end
    end

    // Levels and events delivered to the radio core.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            to_core_q <= '0;
        end else begin
            to_core_q.din <= (code == P1FM_F_DIN) && pin_s_q;
            to_core_q.tx_mod_data <= (code == P1FM_F_TXDATA) && pin_s_q;
            to_core_q.retx_req <= (code == P1FM_F_RETX) && pin_s_q;
            // Edge modes compare the current and the previous pin sample.
            case (p1fm_code_e'(code))
                P1FM_F_INT_FALL: to_core_q.ext_int <= pin_prev_q && !pin_s_q;
                P1FM_F_INT_RISE: to_core_q.ext_int <= !pin_prev_q && pin_s_q;
                P1FM_F_INT_CHG: to_core_q.ext_int <= pin_prev_q != pin_s_q;
                default: to_core_q.ext_int <= 1'b0;
            endcase
        end
    end

    // Every output is taken straight from its register, except waitrequest, which is the inverted acknowledge.
    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = !ack_q;
    assign core_o = to_core_q;
    assign pin_o = pin_o_q;
    assign pin_oe_o = pin_oe_q;
    assign pin1_pullup_enable_o = pup_q;
    assign pin1_drive_strength_o = drv_q;
    assign analog_en_o = ana_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking p1fm_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Write to the configuration register seen on the bus.
    sequence s_cfg_write;
        avs_write_i && ack_q && avs_byteenable_i[0] && avs_address_i == P1FM_CFG_ADDR;
    endsequence

    // Request raised while idle.
    sequence s_req_start;
        (avs_read_i || avs_write_i) && !ack_q;
    endsequence

    // Configuration fields two edges after the write.
    sequence s_cfg_landed;
        drv_q == $past(avs_writedata_i[7:6], 2) && code == $past(avs_writedata_i[4:0], 2);
    endsequence

    // Falling edge while falling mode is held.
    sequence s_fall_seen;
        (code == P1FM_F_INT_FALL) [*2] ##1 (code == P1FM_F_INT_FALL && pin_prev_q && !pin_s_q);
    endsequence

    // Interrupt mode selected one edge earlier.
    sequence s_was_int_mode;
        $past(code) inside {P1FM_F_INT_FALL, P1FM_F_INT_RISE, P1FM_F_INT_CHG};
    endsequence

    a_cfg_write_lands: assert property (s_cfg_write |=> ##1 s_cfg_landed)
        else $error("configuration write not reflected");

    a_bus_one_wait: assert property (s_req_start |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not after exactly one wait state");

    a_pullup_gate: assert property (pup_q |-> $past(cfg_q[P1FM_PUP_BIT]) && $past(p1fm_is_din(code)))
        else $error("pull-up connected outside digital input");
    a_por_inverted: assert property (code == P1FM_F_POR_N |=> pin_oe_o && pin_o == !$past(core_i.por))
        else $error("inverted reset not on pin");
    a_wakeup_out: assert property (code == P1FM_F_WAKEUP |=> pin_o == $past(core_i.wakeup_timer))
        else $error("wake-up timer level wrong");
    a_lowbatt_out: assert property (code == P1FM_F_LOWBATT |=> pin_o == $past(core_i.low_batt))
        else $error("low battery level wrong");
    a_dout_level: assert property (code == P1FM_F_DOUT |=> pin_oe_o && pin_o == $past(dout_q))
        else $error("direct output level wrong");
    a_din_release: assert property (p1fm_is_din(code) |=> !pin_oe_o)
        else $error("pin driven in input mode");
    a_int_fall: assert property (s_fall_seen |=> core_o.ext_int)
        else $error("falling edge interrupt missed");
    a_int_only_mode: assert property (core_o.ext_int |-> s_was_int_mode)
        else $error("interrupt outside interrupt mode");
    a_analog_cut: assert property (p1fm_is_analog(code) [*2] |=> !pin_oe_o && !pin_s_q && analog_en_o)
        else $error("digital path not cut in analog mode");
    a_test_release: assert property (p1fm_is_test(code) |=> !pin_oe_o)
        else $error("test code drives pin");
    a_dclk_out: assert property (code == P1FM_F_DCLK |=> pin_o == $past(core_i.data_clk))
        else $error("data clock not on pin");
    a_retx_sample: assert property (code == P1FM_F_RETX [*2] |=> core_o.retx_req == $past(pin_i, 2))
        else $error("retransmission request not sampled");
    a_state_out: assert property (code == P1FM_F_TXSTATE |=> pin_o == $past(core_i.tx_state))
        else $error("transmit state level wrong");
    a_afull_out: assert property (code == P1FM_F_RXAFULL |=> pin_o == $past(core_i.rx_afull))
        else $error("receive almost-full level wrong");
    a_rxdata_out: assert property (code == P1FM_F_RXDATA |=> pin_o == $past(core_i.rx_data))
        else $error("receive data not on pin");
    a_ant_out: assert property (code == P1FM_F_ANT2 |=> pin_o == $past(core_i.ant2))
        else $error("antenna 2 control wrong");
    a_preamble_out: assert property (code == P1FM_F_PRE_BAD |=> pin_o == $past(core_i.pre_bad))
        else $error("invalid preamble level wrong");
    a_sync_out: assert property (code == P1FM_F_SYNC |=> pin_o == $past(core_i.sync_det))
        else $error("sync detect level wrong");
    a_cca_out: assert property (code == P1FM_F_CCA |=> pin_o == $past(core_i.cca))
        else $error("channel assessment level wrong");
    a_const_levels: assert property (code > P1FM_F_HIGH |=> pin_oe_o && !pin_o)
        else $error("unassigned code not low");
    a_const_high: assert property (code == P1FM_F_HIGH |=> pin_oe_o && pin_o)
        else $error("code above assessment not high");

    // Rising and any-change interrupt modes.
    a_int_rise: assert property (
        code == P1FM_F_INT_RISE && !pin_prev_q && pin_s_q |=> core_o.ext_int)
        else $error("rising edge interrupt missed");
    a_int_change: assert property (
        code == P1FM_F_INT_CHG && pin_prev_q != pin_s_q |=> core_o.ext_int)
        else $error("level change interrupt missed");

    // Input levels to the core and the input gate.
    a_din_level: assert property (
        code == P1FM_F_DIN |=> core_o.din == $past(pin_s_q))
        else $error("direct input level wrong");
    a_txmod_level: assert property (
        code == P1FM_F_TXDATA |=> core_o.tx_mod_data == $past(pin_s_q))
        else $error("modulation data level wrong");
    a_input_gate: assert property (
        !p1fm_is_din(code) |=> !pin_s_q && !core_o.din)
        else $error("input path open outside input mode");

    // Register fields on outputs and read data.
    a_drive_field: assert property (
        1'b1 |=> pin1_drive_strength_o == $past(cfg_q[P1FM_DRV_MSB:P1FM_DRV_LSB]))
        else $error("drive strength not on output");
    a_cfg_readback: assert property (
        avs_read_i && !ack_q && avs_address_i == P1FM_CFG_ADDR
        |=> avs_readdata_o[7:0] == $past(cfg_q))
        else $error("configuration read data wrong");

    // Remaining core status outputs.
    a_txafull_out: assert property (
        code == P1FM_F_TXAFULL |=> pin_o == $past(core_i.tx_afull))
        else $error("transmit almost-full level wrong");
    a_rxstate_out: assert property (
        code == P1FM_F_RXSTATE |=> pin_o == $past(core_i.rx_state))
        else $error("receive state level wrong");
    a_ant1_out: assert property (
        code == P1FM_F_ANT1 |=> pin_o == $past(core_i.ant1))
        else $error("antenna 1 control wrong");
    a_preok_out: assert property (
        code == P1FM_F_PRE_OK |=> pin_o == $past(core_i.pre_ok))
        else $error("valid preamble level wrong");

endmodule

// ---- tb/p1fm_pin_partner.sv ----
// Model of the external logic that listens to or drives pin 1.
`timescale 1ns/1ps
module p1fm_pin_partner (
    input wire logic clk_i,
    input wire logic drive_en_i,
    input wire logic level_i,
    input wire logic blk_lvl_i,
    input wire logic blk_oe_i,
    input wire logic pullup_i,
    output logic wire_o
);
    logic float_q = 1'b0; // Pattern seen on a line that nobody drives.

    // The undriven pattern flips every cycle so a stale level never passes.
    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end

    // Wire level: the block first, then the far side, then the pull-up.
    always_comb begin
        if (blk_oe_i) begin
            wire_o = blk_lvl_i;
        end else if (drive_en_i) begin
            wire_o = level_i;
        end else if (pullup_i) begin
            wire_o = 1'b1;
        end else begin
            wire_o = float_q;
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench for the pin-1 function mux.
`timescale 1ns/1ps
module tb_top;
    import p1fm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    p1fm_core_s core_i = '0;
    p1fm_to_core_s core_o;
    p1fm_to_core_s x;
    logic pin_i, pin_o, pin_oe_o, pin1_pullup_enable_o, analog_en_o;
    logic [1:0] pin1_drive_strength_o;
    logic ext_en = 1'b0; // Far side drives the pin when the block lets go.
    logic ext_lvl = 1'b0;
    int miscompares = 0;
    int checked = 0;
    int seed = 32'hd4a7;
    logic [31:0] rd, r;
    logic [7:0] cfg;
    logic [4:0] c;
    logic [1:0] e;
    logic dout = 1'b0;
    logic [4:0] ins [3] = '{5'h03, 5'h10, 5'h11};

    always #20 clk_i = ~clk_i;

    p1fm_pin1_mux i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .core_i(core_i), .core_o(core_o), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin1_pullup_enable_o(pin1_pullup_enable_o),
        .pin1_drive_strength_o(pin1_drive_strength_o), .analog_en_o(analog_en_o));
    p1fm_pin_partner i_far (.clk_i(clk_i), .drive_en_i(ext_en), .level_i(ext_lvl),
        .blk_lvl_i(pin_o), .blk_oe_i(pin_oe_o), .pullup_i(pin1_pullup_enable_o), .wire_o(pin_i));

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus access; the request stands until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h00_0000, d};
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20) begin
            miscompares++;
            tally_and_finish();
        end
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    // True for the codes in which the pin is a digital input.
    function automatic logic is_in(input logic [4:0] k);
        return k inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h10, 5'h11};
    endfunction

    // Expected {enable, level} of the pin for a code and the core levels.
    function automatic logic [1:0] exp_pin(input logic [4:0] k, input p1fm_core_s s);
        case (k)
            5'h00: return {1'b1, ~s.por};
            5'h01: return {1'b1, s.wakeup_timer};
            5'h02: return {1'b1, s.low_batt};
            5'h0a: return {1'b1, dout};
            5'h0f: return {1'b1, s.data_clk};
            5'h12: return {1'b1, s.tx_state};
            5'h13: return {1'b1, s.tx_afull};
            5'h14: return {1'b1, s.rx_data};
            5'h15: return {1'b1, s.rx_state};
            5'h16: return {1'b1, s.rx_afull};
            5'h17: return {1'b1, s.ant1};
            5'h18: return {1'b1, s.ant2};
            5'h19: return {1'b1, s.pre_ok};
            5'h1a: return {1'b1, s.pre_bad};
            5'h1b: return {1'b1, s.sync_det};
            5'h1c: return {1'b1, s.cca};
            5'h1d: return 2'b11;
            default: return (k < 5'h1e) ? 2'b00 : 2'b10;
        endcase
    endfunction

    // Counts interrupt pulses after the pin moves from level a to level b.
    task automatic int_try(input logic [4:0] k, input logic a, input logic b, input int exp);
        int cnt;
        cnt = 0;
        bus(1'b1, P1FM_CFG_ADDR, {3'b000, k});
        ext_lvl <= a;
        repeat (6) @(posedge clk_i);
        ext_lvl <= b;
        repeat (8) begin
            @(posedge clk_i);
            cnt += (core_o.ext_int === 1'b1) ? 1 : 0;
        end
        chk("interrupt count", exp, cnt);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, every code with random core levels, inputs, bus corners.
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, P1FM_CFG_ADDR, 8'h00);
        chk("cfg reset", 32'h0000_0000, rd);
        bus(1'b0, 8'h04, 8'h00);
        chk("unmapped read", 32'h0000_0000, rd);
        for (int i = 0; i < 64; i++) begin
            c = i[4:0];
            r = $random(seed);
            cfg = {r[7:5], c};
            if (c == 5'h0a) begin
                dout = r[23];
                bus(1'b1, P1FM_CTRL_ADDR, {7'h00, dout});
            end
            bus(1'b1, P1FM_CFG_ADDR, cfg);
            core_i <= r[22:8];
            repeat (2) @(posedge clk_i);
            e = exp_pin(c, r[22:8]);
            chk("pin enable", e[1], pin_oe_o);
            if (e[1]) begin
                chk("pin level", e[0], pin_o);
            end
            chk("pullup", cfg[5] & is_in(c), pin1_pullup_enable_o);
            chk("drive", cfg[7:6], pin1_drive_strength_o);
            if (!(c inside {5'h08, 5'h09, 5'h0b, 5'h0c, 5'h0d})) begin
                chk("analog", c == 5'h07 || c == 5'h0e, analog_en_o);
            end
            bus(1'b0, P1FM_CFG_ADDR, 8'h00);
            chk("cfg readback", cfg, rd);
        end
        ext_en <= 1'b1;
        for (int j = 0; j < 6; j++) begin
            c = ins[j % 3];
            r = $random(seed);
            bus(1'b1, P1FM_CFG_ADDR, {3'b000, c});
            ext_lvl <= r[0];
            repeat (6) @(posedge clk_i);
            x = '0;
            x.din = (c == 5'h03) & r[0];
            x.tx_mod_data = (c == 5'h10) & r[0];
            x.retx_req = (c == 5'h11) & r[0];
            chk("to core", x, core_o);
            bus(1'b0, P1FM_STAT_ADDR, 8'h00);
            chk("status pin", r[0], rd[P1FM_STAT_PIN_BIT]);
        end
        bus(1'b1, P1FM_CFG_ADDR, 8'h12);
        repeat (4) @(posedge clk_i);
        chk("to core gated", 32'h0000_0000, core_o);
        int_try(5'h04, 1'b1, 1'b0, 1);
        int_try(5'h04, 1'b0, 1'b1, 0);
        int_try(5'h05, 1'b0, 1'b1, 1);
        int_try(5'h05, 1'b1, 1'b0, 0);
        int_try(5'h06, 1'b1, 1'b0, 1);
        int_try(5'h06, 1'b0, 1'b1, 1);
        bus(1'b1, P1FM_CFG_ADDR, 8'h1d);
        avs_byteenable_i <= 4'h0;
        bus(1'b1, P1FM_CFG_ADDR, 8'h00);
        avs_byteenable_i <= 4'hf;
        bus(1'b1, 8'h08, 8'h00);
        bus(1'b0, P1FM_CFG_ADDR, 8'h00);
        chk("masked and unmapped write", 32'h0000_001d, rd);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("reset wait", 32'h0000_0001, avs_waitrequest_o);
        chk("reset pin enable", 32'h0000_0000, pin_oe_o);
        rst_i <= 1'b0;
        bus(1'b0, P1FM_CFG_ADDR, 8'h00);
        chk("cfg after reset", 32'h0000_0000, rd);
        tally_and_finish();
    end

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        tally_and_finish();
    end
endmodule
